/* orpld_decode.v */
// Decode and execute of the OR-with-file and pointer-load instructions.
`timescale 1ns/1ns
`default_nettype none
`include "orpld_defs.vh"
module orpld_decode #(
	parameter NUM_PTR = 3
) (
	input  wire                            clk_sys,
	input  wire                            reset,
	input  wire [15:0]                     instr_word,
	input  wire                            instr_valid,
	input  wire [7:0]                      file_rdata,
	input  wire [3:0]                      bank_select_register,
	output reg  [11:0]                     file_addr,
	output reg  [7:0]                      file_wdata,
	output reg                             file_we,
	output reg  [7:0]                      accumulator,
	output reg                             flag_n,
	output reg                             flag_z,
	output reg  [NUM_PTR*`ORPLD_PTR_W-1:0] indirect_pointer,
	output reg                             busy,
	output reg                             illegal_word,
	output reg  [3:0]                      phase_out
);

	// One-hot codes of the two-word sequencer.
	localparam ST_IDLE = 2'b01;
	localparam ST_LP2  = 2'b10;

	// A pointer is as wide as the literal that the two words carry.
	localparam PTR_W = `ORPLD_PTR_W;
	localparam ALL_W = NUM_PTR * PTR_W;

	// Instruction cycle phase and its two decoded edges.
	wire [3:0]       phase;
	wire             at_q1;
	wire             at_q4;

	// Sequencer of the two-word pointer load.
	reg  [1:0]       state;
	reg  [1:0]       next_state;
	reg  [1:0]       ptr_sel;
	reg  [1:0]       next_ptr_sel;

	// Instruction word held for the whole instruction cycle.
	reg  [15:0]      cur_word;

	// Operand fields of the held word.
	wire [5:0]       word_opcode;
	wire [9:0]       word_lp_opcode;
	wire [7:0]       word_prefix;
	wire             word_dest;
	wire             word_bank;
	wire [7:0]       word_faddr;
	wire [1:0]       word_idx;
	wire [3:0]       word_lit_high;
	wire [7:0]       word_lit_low;

	// Decode results and the OR datapath.
	reg              is_or;
	reg              is_lp1;
	reg              is_lp2;
	reg  [7:0]       or_result;

	// Next contents of every pointer, built per entry below.
	wire [ALL_W-1:0] next_pointer;

	// Phase generator of the four-phase instruction cycle.
	orpld_phase u_phase (
		.clk_sys (clk_sys),
		.reset   (reset),
		.phase   (phase)
	);

	// Decoded phase markers.
	assign at_q1 = (phase == `ORPLD_Q1);
	assign at_q4 = (phase == `ORPLD_Q4);

	// Latches the word offered by fetch at the start of each instruction cycle.
	// An absent word becomes all zeros, which decodes as neither instruction.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cur_word <= `ORPLD_WORD_RST;
		end else if (at_q1) begin
			cur_word <= instr_valid ? instr_word : `ORPLD_WORD_RST;
		end
	end

	// Splits the held word into its operand fields.
	assign word_opcode    = cur_word[`ORPLD_OPC_HI:`ORPLD_OR_OPC_LO];
	assign word_lp_opcode = cur_word[`ORPLD_OPC_HI:`ORPLD_LP1_OPC_LO];
	assign word_prefix    = cur_word[`ORPLD_OPC_HI:`ORPLD_LP2_OPC_LO];
	assign word_dest      = cur_word[`ORPLD_DEST_BIT];
	assign word_bank      = cur_word[`ORPLD_BANK_BIT];
	assign word_faddr     = cur_word[`ORPLD_FADDR_HI:`ORPLD_FIELD_LO];
	assign word_idx       = cur_word[`ORPLD_IDX_HI:`ORPLD_IDX_LO];
	assign word_lit_high  = cur_word[`ORPLD_LITH_HI:`ORPLD_FIELD_LO];
	assign word_lit_low   = cur_word[`ORPLD_LITL_HI:`ORPLD_FIELD_LO];

	// Classifies the held word; an index past the last pointer is refused.
	always @* begin
		is_or     = (word_opcode == `ORPLD_OR_OPC);
		is_lp1    = (state == ST_IDLE) && (word_lp_opcode == `ORPLD_LP_OPC1)
			&& ({`ORPLD_IDX_PAD, word_idx} < NUM_PTR);
		is_lp2    = (state == ST_LP2) && (word_prefix == `ORPLD_LP_OPC2);
		or_result = accumulator | file_rdata;
	end

	// Drives the data memory address from the operand and the bank bit.
	// Bank bit one uses the bank select; zero forces the fast access bank.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			file_addr <= `ORPLD_ADDR_RST;
		end else if (word_bank) begin
			file_addr <= {bank_select_register, word_faddr};
		end else begin
			file_addr <= {`ORPLD_ACCESS_BANK, word_faddr};
		end
	end

	// Next state of the two-word sequence; it moves only on the Q4 edge.
	always @* begin
		next_state   = state;
		next_ptr_sel = ptr_sel;
		if (at_q4) begin
			case (state)
				ST_IDLE: begin
					if (is_lp1) begin
						next_state   = ST_LP2;
						next_ptr_sel = word_idx;
					end
				end
				ST_LP2: begin
					next_state = ST_IDLE;
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	// Sequencer registers; the selected index is kept for the second word.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state   <= ST_IDLE;
			ptr_sel <= `ORPLD_SEL_RST;
			busy    <= `ORPLD_BIT_RST;
		end else begin
			state   <= next_state;
			ptr_sel <= next_ptr_sel;
			busy    <= (next_state == ST_LP2);
		end
	end

	// Builds the next value of each pointer from the two words of a load.
	// Only the entry named by the index moves; the others hold their value.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PTR; gi = gi + 1) begin : g_ptr
			// Index of this entry, as an integer for comparison with the operand.
			localparam integer PTR_IDX = gi;
			wire [PTR_W-1:0] cur_ptr;
			wire             hit_high;
			wire             hit_low;
			assign cur_ptr  = indirect_pointer[gi*PTR_W +: PTR_W];
			assign hit_high = at_q4 && is_lp1 && ({`ORPLD_IDX_PAD, word_idx} == PTR_IDX);
			assign hit_low  = at_q4 && is_lp2 && ({`ORPLD_IDX_PAD, ptr_sel} == PTR_IDX);
			// First cycle loads the upper bits, the second cycle the low byte.
			assign next_pointer[gi*PTR_W +: PTR_W] =
				hit_high ? {word_lit_high, cur_ptr[`ORPLD_HIGH_LSB-1:0]} :
				hit_low  ? {cur_ptr[PTR_W-1:`ORPLD_HIGH_LSB], word_lit_low} :
				cur_ptr;
		end
	endgenerate

	// Pointer bank register; all pointers clear on reset.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			indirect_pointer <= {NUM_PTR{`ORPLD_PTR_RST}};
		end else begin
			indirect_pointer <= next_pointer;
		end
	end

	// Flags a second word without the load prefix; the low byte then stays as it was.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			illegal_word <= `ORPLD_BIT_RST;
		end else if (at_q4) begin
			illegal_word <= (state == ST_LP2) && !is_lp2;
		end
	end

	// Follows the phase one clock late for observers outside the block.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			phase_out <= `ORPLD_Q1;
		end else begin
			phase_out <= phase;
		end
	end

	// Executes the OR on the Q4 edge; the second word of a load never runs as an OR.
	// Flags follow every OR result, whichever destination it goes to.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			accumulator <= `ORPLD_BYTE_RST;
			flag_n      <= `ORPLD_BIT_RST;
			flag_z      <= `ORPLD_BIT_RST;
			file_wdata  <= `ORPLD_BYTE_RST;
			file_we     <= `ORPLD_BIT_RST;
		end else begin
			file_we <= `ORPLD_BIT_RST;
			if (at_q4 && state == ST_IDLE && is_or) begin
				flag_n <= or_result[`ORPLD_SIGN_BIT];
				flag_z <= (or_result == `ORPLD_ZERO_BYTE);
				if (word_dest) begin
					file_wdata <= or_result;
					file_we    <= `ORPLD_BIT_SET;
				end else begin
					accumulator <= or_result;
				end
			end
		end
	end
endmodule // orpld_decode
`default_nettype wire

/* orpld_defs.vh */
// Constants for the OR-with-file and pointer-load decode block.
`ifndef ORPLD_DEFS_VH
`define ORPLD_DEFS_VH
`define ORPLD_OR_OPC      6'h04
`define ORPLD_LP_OPC1     10'h3b8
`define ORPLD_LP_OPC2     8'hf0
`define ORPLD_NUM_PTR     2'h3
`define ORPLD_ACCESS_BANK 4'h0
`define ORPLD_Q4          4'h8
`define ORPLD_Q1          4'h1
`define ORPLD_PTR_RST     12'h000
`define ORPLD_PTR_W       12
`define ORPLD_OPC_HI      15
`define ORPLD_OR_OPC_LO   10
`define ORPLD_LP1_OPC_LO  6
`define ORPLD_LP2_OPC_LO  8
`define ORPLD_DEST_BIT    9
`define ORPLD_BANK_BIT    8
`define ORPLD_FADDR_HI    7
`define ORPLD_IDX_HI      5
`define ORPLD_IDX_LO      4
`define ORPLD_LITH_HI     3
`define ORPLD_LITL_HI     7
`define ORPLD_FIELD_LO    0
`define ORPLD_SIGN_BIT    7
`define ORPLD_HIGH_LSB    8
`define ORPLD_WORD_RST    16'h0000
`define ORPLD_BYTE_RST    8'h00
`define ORPLD_ADDR_RST    12'h000
`define ORPLD_SEL_RST     2'h0
`define ORPLD_BIT_RST     1'b0
`define ORPLD_BIT_SET     1'b1
`define ORPLD_ZERO_BYTE   8'h00
`define ORPLD_IDX_PAD     30'h0
`endif

/* orpld_phase.v */
// Four-phase instruction cycle generator.
`timescale 1ns/1ns
`default_nettype none
`include "orpld_defs.vh"
module orpld_phase (
	input  wire       clk_sys,
	input  wire       reset,
	output reg  [3:0] phase
);
	// Rotates a one-hot phase marker Q1..Q4.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			phase <= `ORPLD_Q1;
		end else begin
			phase <= {phase[2:0], phase[3]};
		end
	end
endmodule // orpld_phase
`default_nettype wire

/* orpld_mem_model.sv */
// Data memory model behind the decode block.
`timescale 1ns/1ns
`default_nettype none
module orpld_mem_model (
	input  wire logic        clk_sys,
	input  wire logic [11:0] file_addr,
	input  wire logic [7:0]  file_wdata,
	input  wire logic        file_we,
	output var  logic [7:0]  file_rdata
);
	logic [7:0] mem [0:4095];
	// Each cell holds its bank and upper nibble plus one.
	initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i >> 4) + 8'h01;
	assign file_rdata = mem[file_addr];
	// Write-back of a file result.
	always @(posedge clk_sys) if (file_we) mem[file_addr] <= file_wdata;
endmodule // orpld_mem_model
`default_nettype wire

/* orpld_decode_asserts.sv */
// Port checker for the decode block.
`timescale 1ns/1ns
`default_nettype none
module orpld_decode_asserts (
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic [7:0]  file_wdata,
	input wire logic        file_we,
	input wire logic [7:0]  accumulator,
	input wire logic        flag_n,
	input wire logic        flag_z,
	input wire logic [35:0] indirect_pointer,
	input wire logic        busy,
	input wire logic [3:0]  phase_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_acc_flags: assert property ($changed(accumulator) |->
		flag_z == (accumulator == 8'h00) && flag_n == accumulator[7]) else $error("acc flags");
	a_we_flags: assert property ($rose(file_we) |->
		flag_z == (file_wdata == 8'h00) && flag_n == file_wdata[7]) else $error("we flags");
	a_we_quiet: assert property (file_we |=> !file_we [*3]) else $error("we pulse");
	a_busy_flags: assert property (busy |-> $stable(flag_n) && $stable(flag_z)) else $error("flags moved");
	a_acc_cause: assert property ($changed(accumulator) |-> !file_we && !busy) else $error("acc cause");
	a_ptr_cause: assert property ($changed(indirect_pointer) |-> $rose(busy) || $fell(busy))
		else $error("ptr cause");
	a_busy_len: assert property ($rose(busy) |-> ##[1:5] $fell(busy)) else $error("busy len");
	a_phase_wrap: assert property (phase_out == 4'h8 |=> phase_out == 4'h1) else $error("wrap");
	a_phase_step: assert property (phase_out == 4'h2 |=> phase_out == 4'h4) else $error("step");
	c_we: cover property (file_we);
	c_busy: cover property ($rose(busy));
	c_acc: cover property ($changed(accumulator));
endmodule // orpld_decode_asserts
bind orpld_decode orpld_decode_asserts i_chk (.clk_sys(clk_sys), .reset(reset), .file_wdata(file_wdata),
	.file_we(file_we), .accumulator(accumulator), .flag_n(flag_n), .flag_z(flag_z),
	.indirect_pointer(indirect_pointer), .busy(busy), .phase_out(phase_out));
`default_nettype wire

/* orpld_decode_tb.sv */
// Self-checking bench for the decode block.
`timescale 1ns/1ns
`default_nettype none
module orpld_decode_tb;
	logic        clk_sys = 0, reset = 1, instr_valid = 0, file_we, flag_n, flag_z, busy, illegal_word;
	logic [15:0] instr_word = 16'h0000;
	logic [7:0]  file_rdata, file_wdata, accumulator;
	logic [3:0]  bank_select_register = 4'h0, phase_out;
	logic [11:0] file_addr;
	logic [35:0] indirect_pointer;
	int          mismatches = 0, tests_run = 0, cycles = 0;
	// Clock and hang guard.
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (++cycles > 500) begin
		mismatches++;
		summarize;
	end
	orpld_decode i_dut (.clk_sys, .reset, .instr_word, .instr_valid, .file_rdata, .bank_select_register,
		.file_addr, .file_wdata, .file_we, .accumulator, .flag_n, .flag_z, .indirect_pointer, .busy,
		.illegal_word, .phase_out);
	orpld_mem_model i_mem (.clk_sys, .file_addr, .file_wdata, .file_we, .file_rdata);
	task chk(string name, logic [11:0] seen, logic [11:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Offers one word to fetch; called in the time step of a Q4 edge or of reset release.
	task drive(logic [15:0] w, logic [3:0] bank);
		instr_word <= w;
		instr_valid <= 1'b1;
		bank_select_register <= bank;
	endtask
	// Lets the Q1 edge take the word, withdraws it and runs to the Q4 edge.
	task run;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	task issue(logic [15:0] w, logic [3:0] bank);
		drive(w, bank);
		run;
	endtask
	// Looks at the results of a Q4 edge half a clock later.
	task look;
		@(negedge clk_sys);
	endtask
	// Lets one empty instruction cycle pass, up to its Q4 edge.
	task idle;
		repeat (4) @(posedge clk_sys);
	endtask
	task or_zero;
		issue(16'h11f5, 4'hf);
		look;
		chk("zaddr", file_addr, 12'hff5);
		chk("zacc", accumulator, 8'h00);
		chk("zflag", flag_z, 1'b1);
		chk("zneg", flag_n, 1'b0);
		chk("phase", phase_out, 4'h8);
		idle;
	endtask
	task or_to_acc;
		issue(16'h1112, 4'h3);
		look;
		chk("acc", accumulator, 8'h32);
		chk("we", file_we, 1'b0);
		chk("nz", flag_z, 1'b0);
		idle;
		chk("kept", i_mem.mem[12'h312], 8'h32);
	endtask
	task or_to_file;
		issue(16'h1212, 4'h3);
		look;
		chk("addr", file_addr, 12'h012);
		chk("wdata", file_wdata, 8'h32);
		chk("we", file_we, 1'b1);
		chk("acc", accumulator, 8'h32);
		idle;
		chk("mem", i_mem.mem[12'h012], 8'h32);
	endtask
	task or_negative;
		issue(16'h11f0, 4'h7);
		look;
		chk("acc", accumulator, 8'hb2);
		chk("neg", flag_n, 1'b1);
		idle;
	endtask
	task ptr_load;
		issue(16'hee23, 4'h0);
		drive(16'hf0ab, 4'h0);
		look;
		chk("busy", busy, 1'b1);
		chk("high", indirect_pointer[35:24], 12'h300);
		run;
		look;
		chk("ptr2", indirect_pointer[35:24], 12'h3ab);
		chk("ptr1", indirect_pointer[23:12], 12'h000);
		chk("ptr0", indirect_pointer[11:0], 12'h000);
		chk("idle", busy, 1'b0);
		chk("neg", flag_n, 1'b1);
		chk("legal", illegal_word, 1'b0);
		idle;
	endtask
	task ptr_limits;
		issue(16'hee3f, 4'h0);
		issue(16'hf0ff, 4'h0);
		look;
		chk("idx3a", indirect_pointer[35:24], 12'h3ab);
		chk("idx3b", indirect_pointer[23:12], 12'h000);
		chk("idx3c", indirect_pointer[11:0], 12'h000);
		idle;
		issue(16'hee0f, 4'h0);
		issue(16'hf0ff, 4'h0);
		look;
		chk("ptr0", indirect_pointer[11:0], 12'hfff);
		idle;
	endtask
	task ptr_bad;
		issue(16'hee1f, 4'h0);
		issue(16'h1112, 4'h3);
		look;
		chk("bad", illegal_word, 1'b1);
		chk("ptr1", indirect_pointer[23:12], 12'hf00);
		chk("bacc", accumulator, 8'hb2);
		idle;
	endtask
	// Reset, then each scenario in turn.
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		or_zero;
		or_to_acc;
		or_to_file;
		or_negative;
		ptr_load;
		ptr_limits;
		ptr_bad;
		summarize;
	end
endmodule // orpld_decode_tb
`default_nettype wire
